// file: design/rt_mode_code_auto_handler.sv
// Overview of operation
// - Auto: MC4 or matched MC20 shuts inactive transmitter
// - Transmit-only setting 0 also disables inactive receiver
// - Shutdown sets built-in-test status bits 15-12
// - Auto mode: MC5 or matched MC21 re-enables inactive transmitter and receiver
// - Override clears built-in-test status bits 15-12
// - Option 11 loads sync data unconditionally
// - Non-broadcast sync load completes before status
// - Option 00: no load, status still sent
// - Option 01 loads when data bit0 is 0
// - Option 10 loads when data bit0 is 1
// - Clear option 0: MC16 clears service request first
// - Reset option 0: MC8 soft reset, after status
// - Auto shutdown off: status only, host inhibits
// - Shutdown acts only on the inactive bus
module rt_mode_code_auto_handler (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Configuration
  input  wire logic        auto_bus_shutdown_enable,
  input  wire logic        shutdown_transmit_only,
  input  wire logic [1:0]  sync_load_option,
  input  wire logic        vector_service_clear_option,
  input  wire logic        reset_command_option,
  // Received mode command from the protocol engine
  input  wire logic        mc_valid,
  input  wire logic [4:0]  mc_code,
  input  wire logic        mc_broadcast,
  input  wire logic        mc_on_bus_b,
  input  wire logic [15:0] mc_data,
  input  wire logic        bus_select_match,
  // Status word transmitter handshake
  input  wire logic        status_tx_done,
  // Time base
  input  wire logic        time_tick,
  // Status word transmitter request
  output logic             status_tx_start,
  // Bus enables
  output logic             transmit_inhibit_bus_a,
  output logic             transmit_inhibit_bus_b,
  output logic             receive_disable_bus_a,
  output logic             receive_disable_bus_b,
  // Built-in-test shutdown status, bits 15-12
  output logic [3:0]       shutdown_status,
  // Side effects
  output logic             service_request_clear,
  output logic             soft_terminal_reset,
  output logic             time_tag_loaded,
  output logic [15:0]      time_tag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_code_pkg::handler_state_e state;
    logic [1:0]                    tx_off;
    logic [1:0]                    rx_off;
    logic                          send_status;
    logic                          reset_after;
    logic                          status_go;
    logic                          sr_clear;
    logic                          soft_reset;
    logic                          load;
    logic [15:0]                   load_value;
    logic                          loaded;
  } handler_s;

  handler_s q;
  handler_s d;

  time_tag_if tt ();

  time_tag_counter u_time_tag (
    .clock   (clock),
    .reset_n (reset_n),
    .tt      (tt.counter)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic       is_shutdown;
  logic       is_override;
  logic       sync_load_ok;
  logic [1:0] inactive_mask;

  always_comb
  begin
    is_shutdown = (mc_code == mode_code_pkg::MC_TX_SHUTDOWN) ||
                  ((mc_code == mode_code_pkg::MC_SEL_TX_SHUTDOWN) && bus_select_match);
    is_override = (mc_code == mode_code_pkg::MC_TX_OVERRIDE) ||
                  ((mc_code == mode_code_pkg::MC_SEL_TX_OVERRIDE) && bus_select_match);
    // Bit 1 stands for bus A, bit 0 for bus B; the receiving bus is never touched
    inactive_mask = mc_on_bus_b ? 2'h2 : 2'h1;
    unique case (sync_load_option)
      mode_code_pkg::SYNC_HOST_ONLY:    sync_load_ok = 1'b0;
      mode_code_pkg::SYNC_LOAD_IF_EVEN: sync_load_ok =
        !mc_data[mode_code_pkg::SYNC_FLAG_BIT];
      mode_code_pkg::SYNC_LOAD_IF_ODD:  sync_load_ok =
        mc_data[mode_code_pkg::SYNC_FLAG_BIT];
      mode_code_pkg::SYNC_LOAD_ALWAYS:  sync_load_ok = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d             = q;
    d.status_go   = 1'b0;
    d.sr_clear    = 1'b0;
    d.soft_reset  = 1'b0;
    d.load        = 1'b0;
    d.loaded      = 1'b0;

    // Soft reset reactivates every shut down transmitter and receiver; a command
    // taken in the same cycle is applied on top so its shutdown is not lost
    if (q.soft_reset)
    begin
      d.tx_off = mode_code_pkg::BUS_OFF_RESET;
      d.rx_off = mode_code_pkg::BUS_OFF_RESET;
    end

    unique case (q.state)
      mode_code_pkg::ST_IDLE:
      begin
        if (mc_valid)
        begin
          d.state       = mode_code_pkg::ST_ACT;
          d.send_status = !mc_broadcast;
          d.reset_after = 1'b0;

          // With automatic shutdown off only the status goes out
          if (auto_bus_shutdown_enable && is_shutdown)
          begin
            d.tx_off = d.tx_off | inactive_mask;
            if (!shutdown_transmit_only)
            begin
              d.rx_off = d.rx_off | inactive_mask;
            end
          end

          if (auto_bus_shutdown_enable && is_override)
          begin
            d.tx_off = d.tx_off & ~inactive_mask;
            d.rx_off = d.rx_off & ~inactive_mask;
          end

          if ((mc_code == mode_code_pkg::MC_SYNC_WITH_DATA) && sync_load_ok)
          begin
            d.load       = 1'b1;
            d.load_value = mc_data;
          end

          // Option 1 leaves the service request bit to the host
          if ((mc_code == mode_code_pkg::MC_TX_VECTOR) && !vector_service_clear_option)
          begin
            d.sr_clear = 1'b1;
          end

          // Option 1 leaves terminal reset to the host
          if ((mc_code == mode_code_pkg::MC_RESET_TERMINAL) && !reset_command_option)
          begin
            d.reset_after = 1'b1;
          end
        end
      end

      mode_code_pkg::ST_ACT:
      begin
        // Counter and service request have settled by this edge, so status may go
        d.loaded    = q.load;
        d.status_go = q.send_status;
        if (q.reset_after && q.send_status)
        begin
          d.state = mode_code_pkg::ST_WAIT_STATUS;
        end
        else
        begin
          d.state      = mode_code_pkg::ST_IDLE;
          d.soft_reset = q.reset_after;
        end
      end

      mode_code_pkg::ST_WAIT_STATUS:
      begin
        // Reset must not cut the status word short
        if (status_tx_done)
        begin
          d.state      = mode_code_pkg::ST_IDLE;
          d.soft_reset = 1'b1;
        end
      end

      default:
      begin
        d.state = mode_code_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q.state       <= mode_code_pkg::ST_IDLE;
      q.tx_off      <= mode_code_pkg::BUS_OFF_RESET;
      q.rx_off      <= mode_code_pkg::BUS_OFF_RESET;
      q.send_status <= 1'b0;
      q.reset_after <= 1'b0;
      q.status_go   <= 1'b0;
      q.sr_clear    <= 1'b0;
      q.soft_reset  <= 1'b0;
      q.load        <= 1'b0;
      q.load_value  <= mode_code_pkg::TIME_TAG_RESET;
      q.loaded      <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tt.load       = q.load;
  assign tt.load_value = q.load_value;
  assign tt.tick       = time_tick;

  assign status_tx_start        = q.status_go;
  assign transmit_inhibit_bus_a = q.tx_off[1];
  assign transmit_inhibit_bus_b = q.tx_off[0];
  assign receive_disable_bus_a  = q.rx_off[1];
  assign receive_disable_bus_b  = q.rx_off[0];
  assign shutdown_status[mode_code_pkg::SD_TX_A_POS] = q.tx_off[1];
  assign shutdown_status[mode_code_pkg::SD_TX_B_POS] = q.tx_off[0];
  assign shutdown_status[mode_code_pkg::SD_RX_A_POS] = q.rx_off[1];
  assign shutdown_status[mode_code_pkg::SD_RX_B_POS] = q.rx_off[0];
  assign service_request_clear  = q.sr_clear;
  assign soft_terminal_reset    = q.soft_reset;
  assign time_tag_loaded        = q.loaded;
  assign time_tag               = tt.count;

endmodule

// file: design/mode_code_pkg.sv
package mode_code_pkg;

  // ----------------------------------------------------------------
  // Mode code numbers
  // ----------------------------------------------------------------
  localparam logic [4:0] MC_TX_SHUTDOWN       = 5'h04;
  localparam logic [4:0] MC_TX_OVERRIDE       = 5'h05;
  localparam logic [4:0] MC_RESET_TERMINAL    = 5'h08;
  localparam logic [4:0] MC_TX_VECTOR         = 5'h10;
  localparam logic [4:0] MC_SYNC_WITH_DATA    = 5'h11;
  localparam logic [4:0] MC_SEL_TX_SHUTDOWN   = 5'h14;
  localparam logic [4:0] MC_SEL_TX_OVERRIDE   = 5'h15;

  // ----------------------------------------------------------------
  // Sync load option codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SYNC_HOST_ONLY       = 2'h0;
  localparam logic [1:0] SYNC_LOAD_IF_EVEN    = 2'h1;
  localparam logic [1:0] SYNC_LOAD_IF_ODD     = 2'h2;
  localparam logic [1:0] SYNC_LOAD_ALWAYS     = 2'h3;

  // ----------------------------------------------------------------
  // Shutdown status field (bits 15-12 of the built-in-test word)
  // ----------------------------------------------------------------
  localparam int unsigned SD_TX_A_POS         = 3;
  localparam int unsigned SD_TX_B_POS         = 2;
  localparam int unsigned SD_RX_A_POS         = 1;
  localparam int unsigned SD_RX_B_POS         = 0;
  localparam int unsigned SYNC_FLAG_BIT       = 0;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W              = 16;
  localparam logic [15:0] TIME_TAG_RESET      = 16'h0000;
  localparam logic [1:0]  BUS_OFF_RESET       = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE        = 2'b00,
    ST_ACT         = 2'b01,
    ST_WAIT_STATUS = 2'b10
  } handler_state_e;

endpackage

// file: design/time_tag_if.sv
interface time_tag_if;
  logic        load;
  logic [15:0] load_value;
  logic        tick;
  logic [15:0] count;

  modport owner   (output load, output load_value, output tick, input count);
  modport counter (input load, input load_value, input tick, output count);
endinterface

// file: design/time_tag_counter.sv
module time_tag_counter (
  // Clock and reset
  input wire logic         clock,
  input wire logic         reset_n,
  // Load and count
  time_tag_if.counter      tt
);

  typedef struct packed {
    logic [15:0] count;
  } counter_s;

  counter_s q;
  counter_s d;

  always_comb
  begin
    d = q;
    // A load takes priority so the loaded value is not skewed by a tick
    if (tt.load)
    begin
      d.count = tt.load_value;
    end
    else if (tt.tick)
    begin
      d.count = q.count + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q.count <= mode_code_pkg::TIME_TAG_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign tt.count = q.count;

endmodule

// file: verification/mode_code_properties.sv
module mode_code_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Configuration
  input wire logic        auto_bus_shutdown_enable,
  input wire logic        shutdown_transmit_only,
  input wire logic [1:0]  sync_load_option,
  input wire logic        vector_service_clear_option,
  input wire logic        reset_command_option,
  // Command
  input wire logic        mc_valid,
  input wire logic [4:0]  mc_code,
  input wire logic        mc_broadcast,
  input wire logic        mc_on_bus_b,
  input wire logic [15:0] mc_data,
  input wire logic        bus_select_match,
  input wire logic        status_tx_done,
  // Results
  input wire logic        status_tx_start,
  input wire logic        transmit_inhibit_bus_a,
  input wire logic        transmit_inhibit_bus_b,
  input wire logic        receive_disable_bus_a,
  input wire logic        receive_disable_bus_b,
  input wire logic [3:0]  shutdown_status,
  input wire logic        service_request_clear,
  input wire logic        soft_terminal_reset,
  input wire logic        time_tag_loaded,
  input wire logic [15:0] time_tag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // Codes 4, 5, 20 and 21 share bits 3-1; bit 0 tells override from shutdown
  wire bsd = mc_valid && mc_code[3:1] == 3'h2 && (!mc_code[4] || bus_select_match);
  wire sd  = bsd && auto_bus_shutdown_enable && !mc_code[0];
  wire ov  = bsd && auto_bus_shutdown_enable && mc_code[0];
  wire sy  = mc_valid && mc_code == mode_code_pkg::MC_SYNC_WITH_DATA && !mc_broadcast;
  wire d0  = mc_data[0];

  shut_from_a_a: assert property (
    sd && !mc_on_bus_b |=> transmit_inhibit_bus_b && $stable(transmit_inhibit_bus_a)
    && receive_disable_bus_b == ($past(receive_disable_bus_b) || !shutdown_transmit_only)
    && shutdown_status[2])
    else $error("shutdown from bus A wrong");
  shut_from_b_a: assert property (
    sd && mc_on_bus_b |=> transmit_inhibit_bus_a && $stable(transmit_inhibit_bus_b)
    && receive_disable_bus_a == ($past(receive_disable_bus_a) || !shutdown_transmit_only)
    && shutdown_status[3])
    else $error("shutdown from bus B wrong");
  override_bus_a: assert property (
    ov && !mc_on_bus_b |=> !transmit_inhibit_bus_b && !receive_disable_bus_b
    && shutdown_status[2] == 1'b0 && shutdown_status[0] == 1'b0)
    else $error("override wrong");
  override_bus_b_a: assert property (
    ov && mc_on_bus_b |=> !transmit_inhibit_bus_a && !receive_disable_bus_a
    && shutdown_status[3] == 1'b0 && shutdown_status[1] == 1'b0)
    else $error("override from bus B wrong");
  status_mirror_a: assert property (
    shutdown_status == {transmit_inhibit_bus_a, transmit_inhibit_bus_b,
    receive_disable_bus_a, receive_disable_bus_b})
    else $error("shutdown status differs from enables");
  reset_clears_a: assert property (
    soft_terminal_reset && !mc_valid |=> shutdown_status == 4'h0)
    else $error("soft reset left a shutdown");
  sync_broadcast_a: assert property (
    mc_valid && mc_code == mode_code_pkg::MC_SYNC_WITH_DATA && mc_broadcast
    && sync_load_option == mode_code_pkg::SYNC_LOAD_ALWAYS |-> ##2 time_tag_loaded
    && !status_tx_start && time_tag == $past(mc_data, 2))
    else $error("broadcast sync load wrong");
  host_shutdown_a: assert property (
    bsd && !auto_bus_shutdown_enable |=> $stable(shutdown_status)[*2])
    else $error("shutdown changed while manual");
  vector_clear_a: assert property (
    mc_valid && mc_code == mode_code_pkg::MC_TX_VECTOR && !mc_broadcast
    |=> service_request_clear != vector_service_clear_option ##1 status_tx_start)
    else $error("service request clear wrong");
  sync_always_a: assert property (
    sy && sync_load_option == mode_code_pkg::SYNC_LOAD_ALWAYS |-> ##2 time_tag_loaded
    && status_tx_start && time_tag == $past(mc_data, 2))
    else $error("sync load wrong");
  sync_none_a: assert property (
    sy && sync_load_option == mode_code_pkg::SYNC_HOST_ONLY
    |-> ##2 status_tx_start && !time_tag_loaded)
    else $error("sync without load wrong");
  sync_parity_a: assert property (
    sy && ^sync_load_option |-> ##2 time_tag_loaded == ($past(d0, 2) == sync_load_option[1]))
    else $error("conditional sync load wrong");
  soft_reset_a: assert property (
    soft_terminal_reset |-> !reset_command_option
    && ($past(status_tx_done) || $past(mc_broadcast, 2)))
    else $error("soft reset at wrong time");
endmodule

bind rt_mode_code_auto_handler mode_code_checker mode_code_checker_i (.*);

// file: verification/status_word_sender.sv
module status_word_sender (
  // Clock
  input wire logic       clock,
  // Handshake
  input wire logic       status_tx_start,
  input wire logic [3:0] delay,
  output logic           status_tx_done = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // Status word length, prompt or slow
  // ------------------------------------------------
  logic [4:0] left_q = 5'h00;

  always @(posedge clock)
  begin
    status_tx_done <= left_q == 5'h01;
    if (status_tx_start)
      left_q <= {1'b0, delay};
    else if (left_q != 5'h00)
      left_q <= left_q - 5'h01;
  end
endmodule

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // Bench
  // ------------------------------------------------
  logic clock = 1'b0, reset_n = 1'b0, time_tick = 1'b0, status_tx_done;
  logic auto_bus_shutdown_enable, shutdown_transmit_only, vector_service_clear_option;
  logic reset_command_option, mc_valid, mc_broadcast, mc_on_bus_b, bus_select_match;
  logic [1:0]  sync_load_option;
  logic [4:0]  mc_code;
  logic [15:0] mc_data, time_tag;
  logic [3:0]  shutdown_status, delay = 4'h1, sd_exp = 4'h0;
  logic status_tx_start, transmit_inhibit_bus_a, transmit_inhibit_bus_b, receive_disable_bus_a;
  logic receive_disable_bus_b, service_request_clear, soft_terminal_reset, time_tag_loaded;
  logic [31:0] seed = 32'h0000_0c53;
  logic        svc_prev = 1'b0;
  logic [23:0] notes[$];
  int          num_errors = 0;
  int          checked = 0;

  always #10 clock = ~clock;

  rt_mode_code_auto_handler rt_mode_code_auto_handler_i (.*);
  status_word_sender status_word_sender_i (.clock, .status_tx_start, .delay, .status_tx_done);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random ticks and status lengths keep the partner both prompt and slow
  always @(posedge clock)
  begin
    seed <= lfsr(seed);
    time_tick <= #2 seed[7];
    delay <= #2 {seed[3:1], 1'b1};
  end

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    num_errors += notes.size();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clock)
  begin
    if (status_tx_start === 1'b1 || soft_terminal_reset === 1'b1)
      check("result", {status_tx_start, soft_terminal_reset, shutdown_status, svc_prev,
        time_tag_loaded, time_tag_loaded ? time_tag : 16'h0000},
        notes.size() > 0 ? notes.pop_front() : 24'hxx_xxxx);
    svc_prev <= service_request_clear;
  end

  // Bits: enable, tx only, on bus B, select match, sync option, vector option, reset option
  task automatic cfg(input logic [7:0] c);
    @(posedge clock);
    #2;
    {auto_bus_shutdown_enable, shutdown_transmit_only, mc_on_bus_b, bus_select_match,
      sync_load_option, vector_service_clear_option, reset_command_option} = c;
  endtask

  task automatic cmd(input logic [4:0] code, input logic bcast, input logic [15:0] data);
    logic       ld;
    logic [3:0] clr;
    ld = code == mode_code_pkg::MC_SYNC_WITH_DATA && (sync_load_option == 2'h3
      || ^sync_load_option && data[0] == sync_load_option[1]);
    clr = mc_on_bus_b ? 4'b1010 : 4'b0101;
    if (auto_bus_shutdown_enable && code[3:1] == 3'h2 && (!code[4] || bus_select_match))
      sd_exp = code[0] ? sd_exp & ~clr : sd_exp | (clr & {2'b11, {2{!shutdown_transmit_only}}});
    if (!bcast)
      notes.push_back({2'b10, sd_exp, code == mode_code_pkg::MC_TX_VECTOR
        && !vector_service_clear_option, ld, ld ? data : 16'h0000});
    if (code == mode_code_pkg::MC_RESET_TERMINAL && !reset_command_option)
      notes.push_back({2'b01, sd_exp, 2'b00, 16'h0000});
    @(posedge clock);
    #2;
    {mc_valid, mc_code, mc_broadcast, mc_data} = {1'b1, code, bcast, data};
    @(posedge clock);
    #2;
    mc_valid = 1'b0;
    for (int i = 0; i < 60 && notes.size() > 0; i++)
      @(posedge clock);
    // Let the partner finish its status word so no late done reaches the next command
    repeat (16) @(posedge clock);
    if (code == mode_code_pkg::MC_RESET_TERMINAL && !reset_command_option)
      sd_exp = 4'h0;
  endtask

  initial
  begin
    {mc_valid, mc_code, mc_broadcast, mc_data} = '0;
    {auto_bus_shutdown_enable, shutdown_transmit_only, mc_on_bus_b, bus_select_match,
      sync_load_option, vector_service_clear_option, reset_command_option} = 8'h00;
    repeat (12) @(posedge clock);
    #2;
    reset_n = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      cfg({1'b1, k[1], k[0], 5'h10});
      cmd(k[1] ? mode_code_pkg::MC_SEL_TX_SHUTDOWN : 5'h04, 1'b0, 16'h0000);
      cmd(k[0] ? mode_code_pkg::MC_SEL_TX_OVERRIDE : 5'h05, 1'b0, 16'h0000);
    end
    cfg(8'h80);
    cmd(mode_code_pkg::MC_SEL_TX_SHUTDOWN, 1'b0, 16'h0000);
    cfg(8'h00);
    cmd(mode_code_pkg::MC_TX_SHUTDOWN, 1'b0, 16'h0000);
    for (int k = 0; k < 3; k++)
    begin
      cfg({7'h40, k[1]});
      cmd(mode_code_pkg::MC_TX_SHUTDOWN, 1'b0, 16'h0000);
      cmd(mode_code_pkg::MC_RESET_TERMINAL, k[0], 16'h0000);
    end
    for (int k = 0; k < 2; k++)
    begin
      cfg({6'h00, k[0], 1'b0});
      cmd(mode_code_pkg::MC_TX_VECTOR, 1'b0, 16'h0000);
    end
    for (int i = 0; i < 16; i++)
    begin
      cfg({4'h0, i[1:0], 2'h0});
      cmd(mode_code_pkg::MC_SYNC_WITH_DATA, i[3], {seed[15:1], i[2]});
    end
    cmd(5'h02, 1'b0, 16'h0000);
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    conclude();
  end
endmodule
